// *** sp_defines.svh ***
// Purpose: constants for the four-mode serial port
// Assumes: 8-bit register port, 250 MHz core clock
// Notes:   offsets are register indices on reg_addr
//
// Summary of operation
// - two select bits choose modes 0 to 3
// - mode 0 shifts eight bits LSB first
// - mode 0 receives when allowed and flag clear
// - mode 0 bit rate is core clock/12
// - mode 1 frame: start, eight data, stop
// - modes 1/3 rate from timer overflows
// - buffer write starts a transmission
// - mode 1 ninth shift position is stop
// - tx flag sets when stop bit appears
// - mode 1 receive starts on falling edge
// - completed frame latches data, ninth, flag
// - modes 1-3 keep frame only if flag clear, filter passes
// - mode 2 rate core/64, or core/32 doubled
// - modes 2/3 frame carries eleven bits
// - mode 2 ninth position from tx_ninth_bit
// - mode 2 transmit waits for next tick
// - mode 2 reception latches like mode 1
// - mode 3 is mode 2 with timer rate
// - modes 1-3 receive only while allowed
`ifndef SP_DEFINES_SVH
`define SP_DEFINES_SVH

// register indices
`define SP_ADDR_CTRL      2'h0
`define SP_ADDR_BUF       2'h1
`define SP_ADDR_PWR       2'h2

// power_control field
`define SP_PWR_BAUD_DBL   7

// reset values
`define SP_CTRL_RST       8'h00
`define SP_PWR_RST        8'h00
`define SP_BUF_RST        8'h00

// timing divisors, core clocks per bit except SP_OVS in rate ticks
`define SP_M0_DIV         12
`define SP_M2_DIV         64
`define SP_OVS            16

`endif

// *** sp_pkg.sv ***
// Purpose: types for the four-mode serial port
// Assumes: control byte laid out high bit first
// Notes:   constants live in sp_defines.svh
package sp_pkg;

    // control register fields, bit 7 down to bit 0
    typedef struct packed {
        logic mode_select_high;
        logic mode_select_low;
        logic multiproc_filter;
        logic rx_allow;
        logic tx_ninth_bit;
        logic rx_ninth_bit;
        logic tx_done_flag;
        logic rx_done_flag;
    } sp_ctrl_s;

    // frame sequencer states for modes 1 to 3
    typedef enum logic [2:0] {
        SP_IDLE,
        SP_START,
        SP_DATA,
        SP_NINTH,
        SP_STOP
    } sp_state_e;

endpackage

// *** sp_uart_serial_port.sv ***
// Purpose: four-mode serial port with register port
// Assumes: overflow ticks are one-cycle pulses on clk
// Notes:   rxd pin is two-way in mode 0
`include "sp_defines.svh"
`timescale 1ns/1ps

module sp_uart_serial_port #(
    parameter int OVS = `SP_OVS
) (
    input  wire logic       clk,
    input  wire logic       rst_b,
    input  wire logic [1:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    output logic      [7:0] reg_rdata,
    input  wire logic       tx_ovf_tick,
    input  wire logic       rx_ovf_tick,
    input  wire logic       rxd_in,
    output logic            rxd_out,
    output logic            rxd_oe,
    output logic            txd_out
);

    ////////////////////////////////////////////////////////////////////
    // parameter check

    localparam int M2_LIM = `SP_M2_DIV / OVS;
    localparam int HALF   = OVS / 2;

    generate
        if (OVS < 4 || OVS > 16 || (OVS & (OVS - 1)) != 0 || M2_LIM < 2) begin : g_bad
            $error("OVS must be a power of two from 4 to 16");
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////
    // decode helpers

    function automatic logic sel(input logic [1:0] a, input logic [1:0] idx,
                                 input logic s);
        sel = s && (a == idx);
    endfunction

    ////////////////////////////////////////////////////////////////////
    // registers and state

    sp_pkg::sp_ctrl_s  ctrl_q;
    logic              baud_double_q;
    logic [7:0]        rx_buf_q;
    logic [7:0]        rdata_q;
    logic              rxd_s1_q;
    logic              rxd_s2_q;
    logic              rxd_prev_q;
    logic [1:0]        mode;
    logic              wr_ctrl;
    logic              wr_buf;
    logic              wr_pwr;
    logic              tx_set;
    logic              rx_set;
    logic              rx_nin_d;
    logic [7:0]        rx_data_d;

    // mode 2 divider
    logic [4:0]        m2_cnt_q;
    logic              m2_tick;
    logic              tx_tick;
    logic              rx_tick;

    // mode 0 engine
    logic              m0_busy_q;
    logic              m0_rx_q;
    logic [3:0]        m0_ph_q;
    logic [2:0]        m0_bit_q;
    logic [7:0]        m0_sh_q;
    logic              m0_end;

    // frame transmitter
    sp_pkg::sp_state_e tx_st_q;
    logic              tx_pend_q;
    logic [3:0]        tx_os_q;
    logic [2:0]        tx_bit_q;
    logic [8:0]        tx_sh_q;
    logic              tx_bit_end;
    logic              tx_line;

    // frame receiver
    sp_pkg::sp_state_e rx_st_q;
    logic [3:0]        rx_os_q;
    logic [2:0]        rx_bit_q;
    logic [7:0]        rx_sh_q;
    logic              rx_nin_q;
    logic              rx_bit_end;
    logic              rx_final;

    ////////////////////////////////////////////////////////////////////
    // register port decode

    assign mode    = {ctrl_q.mode_select_high, ctrl_q.mode_select_low};
    assign wr_ctrl = sel(reg_addr, `SP_ADDR_CTRL, reg_wr);
    assign wr_buf  = sel(reg_addr, `SP_ADDR_BUF, reg_wr);
    assign wr_pwr  = sel(reg_addr, `SP_ADDR_PWR, reg_wr);

    // read data stands one cycle, zero otherwise
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rdata_q <= 8'h00;
        end else if (sel(reg_addr, `SP_ADDR_CTRL, reg_rd)) begin
            rdata_q <= ctrl_q;
        end else if (sel(reg_addr, `SP_ADDR_BUF, reg_rd)) begin
            rdata_q <= rx_buf_q;
        end else if (sel(reg_addr, `SP_ADDR_PWR, reg_rd)) begin
            rdata_q <= {baud_double_q, 7'h00};
        end else begin
            rdata_q <= 8'h00;
        end
    end

    assign reg_rdata = rdata_q;

    // control register, hardware set beats software clear
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            ctrl_q <= `SP_CTRL_RST;
        end else begin
            if (wr_ctrl) begin
                ctrl_q <= reg_wdata;
            end
            if (tx_set) begin
                ctrl_q.tx_done_flag <= 1'b1;
            end
            if (rx_set) begin
                ctrl_q.rx_done_flag <= 1'b1;
                ctrl_q.rx_ninth_bit <= rx_nin_d;
            end
        end
    end

    // power control, only the doubling bit is kept
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            baud_double_q <= 1'(`SP_PWR_RST >> `SP_PWR_BAUD_DBL);
        end else if (wr_pwr) begin
            baud_double_q <= reg_wdata[`SP_PWR_BAUD_DBL];
        end
    end

    // receive buffer holds the last kept frame
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rx_buf_q <= `SP_BUF_RST;
        end else if (rx_set) begin
            rx_buf_q <= rx_data_d;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // receive pin synchroniser

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rxd_s1_q   <= 1'b1;
            rxd_s2_q   <= 1'b1;
            rxd_prev_q <= 1'b1;
        end else begin
            rxd_s1_q   <= rxd_in;
            rxd_s2_q   <= rxd_s1_q;
            rxd_prev_q <= rxd_s2_q;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // bit-rate ticks

    // mode 2 sample tick: 64 or 32 clocks per bit
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            m2_cnt_q <= 5'h00;
        end else if (m2_tick) begin
            m2_cnt_q <= 5'h00;
        end else begin
            m2_cnt_q <= m2_cnt_q + 5'h01;
        end
    end

    assign m2_tick = baud_double_q ? (m2_cnt_q >= 5'(M2_LIM / 2 - 1))
                                   : (m2_cnt_q >= 5'(M2_LIM - 1));

    // mode 2 fixed, modes 1 and 3 from timer overflows
    assign tx_tick = (mode == 2'h2) ? m2_tick : tx_ovf_tick;
    assign rx_tick = (mode == 2'h2) ? m2_tick : rx_ovf_tick;

    ////////////////////////////////////////////////////////////////////
    // mode 0 shift register engine

    assign m0_end = m0_busy_q && (m0_ph_q == 4'(`SP_M0_DIV - 1)) && (m0_bit_q == 3'h7);

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            m0_busy_q <= 1'b0;
            m0_rx_q   <= 1'b0;
            m0_ph_q   <= 4'h0;
            m0_bit_q  <= 3'h0;
            m0_sh_q   <= 8'h00;
        end else if (!m0_busy_q) begin
            m0_ph_q  <= 4'h0;
            m0_bit_q <= 3'h0;
            if (mode == 2'h0 && wr_buf) begin
                m0_busy_q <= 1'b1;
                m0_rx_q   <= 1'b0;
                m0_sh_q   <= reg_wdata;
            end else if (mode == 2'h0 && ctrl_q.rx_allow && !ctrl_q.rx_done_flag) begin
                m0_busy_q <= 1'b1;
                m0_rx_q   <= 1'b1;
            end
        end else if (m0_ph_q == 4'(`SP_M0_DIV - 1)) begin
            // bit boundary every twelve clocks
            m0_ph_q  <= 4'h0;
            m0_bit_q <= m0_bit_q + 3'h1;
            m0_sh_q  <= {m0_rx_q ? rxd_s2_q : 1'b0, m0_sh_q[7:1]};
            if (m0_bit_q == 3'h7) begin
                m0_busy_q <= 1'b0;
            end
        end else begin
            m0_ph_q <= m0_ph_q + 4'h1;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // frame transmitter, modes 1 to 3

    assign tx_bit_end = tx_tick && (tx_os_q == 4'(OVS - 1));

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            tx_st_q   <= sp_pkg::SP_IDLE;
            tx_pend_q <= 1'b0;
            tx_os_q   <= 4'h0;
            tx_bit_q  <= 3'h0;
            tx_sh_q   <= 9'h1ff;
        end else begin
            case (tx_st_q)
                sp_pkg::SP_IDLE: begin
                    tx_os_q  <= 4'h0;
                    tx_bit_q <= 3'h0;
                    if (mode != 2'h0 && wr_buf) begin
                        tx_pend_q <= 1'b1;
                        tx_sh_q   <= {(mode == 2'h1) ? 1'b1 : ctrl_q.tx_ninth_bit,
                                      reg_wdata};
                    end else if (tx_pend_q && tx_tick) begin
                        tx_pend_q <= 1'b0;
                        tx_st_q   <= sp_pkg::SP_START;
                    end
                end
                sp_pkg::SP_START: begin
                    if (tx_tick) begin
                        tx_os_q <= tx_os_q + 4'h1;
                    end
                    if (tx_bit_end) begin
                        tx_st_q <= sp_pkg::SP_DATA;
                    end
                end
                sp_pkg::SP_DATA: begin
                    if (tx_tick) begin
                        tx_os_q <= tx_os_q + 4'h1;
                    end
                    if (tx_bit_end) begin
                        tx_bit_q <= tx_bit_q + 3'h1;
                        if (tx_bit_q == 3'h7) begin
                            tx_st_q <= (mode == 2'h1) ? sp_pkg::SP_STOP
                                                      : sp_pkg::SP_NINTH;
                        end
                    end
                end
                sp_pkg::SP_NINTH: begin
                    if (tx_tick) begin
                        tx_os_q <= tx_os_q + 4'h1;
                    end
                    if (tx_bit_end) begin
                        tx_st_q <= sp_pkg::SP_STOP;
                    end
                end
                sp_pkg::SP_STOP: begin
                    if (tx_tick) begin
                        tx_os_q <= tx_os_q + 4'h1;
                    end
                    if (tx_bit_end) begin
                        tx_st_q <= sp_pkg::SP_IDLE;
                    end
                end
                default: begin
                    tx_st_q <= sp_pkg::SP_IDLE;
                end
            endcase
            // bit boundary restarts the count, needed when OVS is below 16
            if (tx_bit_end) begin
                tx_os_q <= 4'h0;
            end
        end
    end

    // line level per frame position
    always_comb begin
        case (tx_st_q)
            sp_pkg::SP_START: tx_line = 1'b0;
            sp_pkg::SP_DATA:  tx_line = tx_sh_q[tx_bit_q];
            sp_pkg::SP_NINTH: tx_line = tx_sh_q[8];
            default:          tx_line = 1'b1;
        endcase
    end

    // flag when stop bit reaches the pin, or mode 0 end
    assign tx_set = (tx_bit_end && (tx_st_q == sp_pkg::SP_NINTH ||
                     (tx_st_q == sp_pkg::SP_DATA && tx_bit_q == 3'h7 && mode == 2'h1)))
                    || (m0_end && !m0_rx_q);

    ////////////////////////////////////////////////////////////////////
    // frame receiver, modes 1 to 3

    assign rx_bit_end = rx_tick && (rx_os_q == 4'(OVS - 1));

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rx_st_q  <= sp_pkg::SP_IDLE;
            rx_os_q  <= 4'h0;
            rx_bit_q <= 3'h0;
            rx_sh_q  <= 8'h00;
            rx_nin_q <= 1'b0;
        end else begin
            case (rx_st_q)
                sp_pkg::SP_IDLE: begin
                    rx_os_q  <= 4'h0;
                    rx_bit_q <= 3'h0;
                    if (mode != 2'h0 && ctrl_q.rx_allow && rxd_prev_q && !rxd_s2_q) begin
                        rx_st_q <= sp_pkg::SP_START;
                    end
                end
                sp_pkg::SP_START: begin
                    if (rx_tick) begin
                        rx_os_q <= rx_os_q + 4'h1;
                    end
                    // mid start bit: high means a glitch
                    if (rx_tick && rx_os_q == 4'(HALF - 1)) begin
                        rx_os_q <= 4'h0;
                        rx_st_q <= rxd_s2_q ? sp_pkg::SP_IDLE : sp_pkg::SP_DATA;
                    end
                end
                sp_pkg::SP_DATA: begin
                    if (rx_tick) begin
                        rx_os_q <= rx_os_q + 4'h1;
                    end
                    if (rx_bit_end) begin
                        rx_sh_q  <= {rxd_s2_q, rx_sh_q[7:1]};
                        rx_bit_q <= rx_bit_q + 3'h1;
                        if (rx_bit_q == 3'h7) begin
                            rx_st_q <= (mode == 2'h1) ? sp_pkg::SP_STOP
                                                      : sp_pkg::SP_NINTH;
                        end
                    end
                end
                sp_pkg::SP_NINTH: begin
                    if (rx_tick) begin
                        rx_os_q <= rx_os_q + 4'h1;
                    end
                    if (rx_bit_end) begin
                        rx_nin_q <= rxd_s2_q;
                        rx_st_q  <= sp_pkg::SP_STOP;
                    end
                end
                sp_pkg::SP_STOP: begin
                    if (rx_tick) begin
                        rx_os_q <= rx_os_q + 4'h1;
                    end
                    if (rx_bit_end) begin
                        rx_st_q <= sp_pkg::SP_IDLE;
                    end
                end
                default: begin
                    rx_st_q <= sp_pkg::SP_IDLE;
                end
            endcase
            // bit boundary restarts the count, needed when OVS is below 16
            if (rx_bit_end) begin
                rx_os_q <= 4'h0;
            end
        end
    end

    // final shift: stop bit sampled mid-bit
    assign rx_final = rx_bit_end && (rx_st_q == sp_pkg::SP_STOP);

    // keep frame in modes 1 to 3 only when flag clear and filter passes; mode 0 frames always
    always_comb begin
        rx_set    = 1'b0;
        rx_nin_d  = ctrl_q.rx_ninth_bit;
        rx_data_d = rx_sh_q;
        if (rx_final && !ctrl_q.rx_done_flag &&
            (!ctrl_q.multiproc_filter || rxd_s2_q)) begin
            rx_set   = 1'b1;
            rx_nin_d = (mode == 2'h1) ? rxd_s2_q : rx_nin_q;
        end else if (m0_end && m0_rx_q) begin
            rx_set    = 1'b1;
            rx_data_d = {rxd_s2_q, m0_sh_q[7:1]};
        end
    end

    ////////////////////////////////////////////////////////////////////
    // pins

    // mode 0: shift clock on txd, data on rxd
    always_comb begin
        if (mode == 2'h0) begin
            txd_out = m0_busy_q ? (m0_ph_q >= 4'(`SP_M0_DIV / 2)) : 1'b1;
            rxd_oe  = m0_busy_q && !m0_rx_q;
            rxd_out = m0_sh_q[0];
        end else begin
            txd_out = tx_line;
            rxd_oe  = 1'b0;
            rxd_out = 1'b1;
        end
    end

endmodule

// *** sp_uart_serial_port_monitor.sv ***
// Purpose: port-level checks for the four-mode serial port
// Assumes: mode and rate copies follow register writes
// Notes:   bit widths judged on low runs of txd_out
`timescale 1ns/1ps

module sp_uart_serial_port_monitor #(
    parameter int OVS = 16
) (
    input wire logic       clk,
    input wire logic       rst_b,
    input wire logic [1:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic       reg_wr,
    input wire logic       reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic       tx_ovf_tick,
    input wire logic       rx_ovf_tick,
    input wire logic       rxd_in,
    input wire logic       rxd_out,
    input wire logic       rxd_oe,
    input wire logic       txd_out
);
    logic [1:0] mode_q;
    logic       dbl_q;
    logic       prev_q;
    int         run_q;
    int         tk_q;

    ////////////////////////////////////////////////////////////////////////////
    // mode and rate copies from register writes
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            mode_q <= 2'h0;
            dbl_q  <= 1'b0;
        end else if (reg_wr && reg_addr == 2'h0) begin
            mode_q <= reg_wdata[7:6];
        end else if (reg_wr && reg_addr == 2'h2) begin
            dbl_q <= reg_wdata[7];
        end
    end

    // length of the current txd level in clocks and in rate ticks
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            prev_q <= 1'b1;
            run_q  <= 0;
            tk_q   <= 0;
        end else begin
            prev_q <= txd_out;
            run_q  <= (txd_out != prev_q) ? 1 : run_q + 1;
            tk_q   <= (txd_out != prev_q) ? int'(tx_ovf_tick) : tk_q + int'(tx_ovf_tick);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
        else $error("read data not zero outside read cycle");
    unmapped_read_a: assert property (reg_rd && reg_addr == 2'h3 |=> reg_rdata == 8'h00)
        else $error("unmapped read not zero");
    power_read_a: assert property (reg_rd && reg_addr == 2'h2 |=> reg_rdata == {dbl_q, 7'h00})
        else $error("power read wrong");
    oe_mode0_a: assert property (rxd_oe |-> mode_q == 2'h0)
        else $error("data pin driven outside mode 0");
    m0_clock_a: assert property (mode_q == 2'h0 && $fell(txd_out) |-> !txd_out [*6] ##1 txd_out [*6])
        else $error("mode 0 shift clock not 12 clocks");
    m0_data_a: assert property (rxd_oe && !txd_out ##1 txd_out |-> $stable(rxd_out))
        else $error("mode 0 data moved at clock rise");
    m2_bit_a: assert property (mode_q == 2'h2 && $rose(txd_out) |-> run_q != 0 && run_q % (dbl_q ? 32 : 64) == 0)
        else $error("mode 2 bit width wrong");
    tick_bit_a: assert property (mode_q[0] && $rose(txd_out) |-> tk_q != 0 && tk_q % OVS == 0)
        else $error("timer rate bit width wrong");
endmodule

// *** sp_serial_peer.sv ***
// Purpose: serial peer on the receive and transmit pins
// Assumes: pin has a pull-up, so released line reads 1
// Notes:   shift8 acts as an external shift register
`timescale 1ns/1ps

module sp_serial_peer (
    input  wire logic clk,
    input  wire logic txd,
    input  wire logic rxd_drv,
    output logic      rxd
);
    // idle line high
    initial begin
        rxd = 1'b1;
    end

    // start bit then nb bits lsb first, each per clocks
    task automatic send(input logic [9:0] bits, input int nb, input int per);
        @(posedge clk);
        rxd <= 1'b0;
        repeat (per) @(posedge clk);
        for (int i = 0; i < nb; i++) begin
            rxd <= bits[i];
            repeat (per) @(posedge clk);
        end
        rxd <= 1'b1;
    endtask

    // sample ten bits after a start bit at mid bit
    task automatic take(input int per, output logic [9:0] got);
        while (txd !== 1'b0) @(posedge clk);
        repeat (per / 2) @(posedge clk);
        for (int i = 0; i < 10; i++) begin
            repeat (per) @(posedge clk);
            got[i] = txd;
        end
    endtask

    // new bit on clock fall, capture on clock rise
    task automatic shift8(input logic [7:0] feed, output logic [7:0] got);
        for (int i = 0; i < 8; i++) begin
            @(negedge txd);
            rxd <= feed[i];
            @(posedge txd);
            got[i] = rxd_drv;
        end
        repeat (8) @(posedge clk);
        rxd <= 1'b1;
    endtask
endmodule

// *** sp_uart_serial_port_tb.sv ***
// Purpose: self-checking bench for the four-mode serial port
// Assumes: rate ticks run every other clock, 32 clocks a bit
// Notes:   frames checked through the peer model
`timescale 1ns/1ps

module sp_uart_serial_port_tb;
    localparam int OVS = 16;
    localparam logic [7:0] RC [6] = '{8'h50, 8'h55, 8'hf0, 8'hf0, 8'h90, 8'h40};  // second keeps flag set
    localparam logic [9:0] RF [6] = '{10'h13c, 10'h10f, 10'h25a, 10'h199, 10'h3c3, 10'h177};
    localparam logic [7:0] RE [6] = '{8'h55, 8'h55, 8'hf1, 8'hf0, 8'h95, 8'h40};
    localparam logic [7:0] RB [6] = '{8'h3c, 8'h3c, 8'h5a, 8'h5a, 8'hc3, 8'hc3};
    logic       clk;
    logic       rst_b;
    logic [1:0] reg_addr;
    logic [7:0] reg_wdata;
    logic       reg_wr;
    logic       reg_rd;
    logic [7:0] reg_rdata;
    logic       tx_ovf_tick;
    logic       rx_ovf_tick;
    logic       rxd_in;
    logic       rxd_out;
    logic       rxd_oe;
    logic       txd_out;
    logic       peer_rxd;
    int         n_errors;
    int         samples_checked;
    int         cycles;
    logic [7:0] rv;
    logic [7:0] b8;
    logic [9:0] fr;

    assign rxd_in = rxd_oe ? rxd_out : peer_rxd; // shared data pin

    sp_uart_serial_port #(.OVS(OVS)) i_sp_uart_serial_port (.clk(clk), .rst_b(rst_b), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .tx_ovf_tick(tx_ovf_tick),
        .rx_ovf_tick(rx_ovf_tick), .rxd_in(rxd_in), .rxd_out(rxd_out), .rxd_oe(rxd_oe), .txd_out(txd_out));
    sp_serial_peer i_sp_serial_peer (.clk(clk), .txd(txd_out), .rxd_drv(rxd_out), .rxd(peer_rxd));

    ////////////////////////////////////////////////////////////////////////////
    // clock
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    // rate ticks on alternate clocks, and the hang limit
    always @(posedge clk) begin
        tx_ovf_tick <= ~tx_ovf_tick;
        rx_ovf_tick <= tx_ovf_tick;
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            n_errors++;
            test_done();
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    task automatic wr(input logic [1:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge clk);
        reg_wr    <= 1'b0;
    endtask

    task automatic rd(input logic [1:0] a, output logic [7:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clk);
        reg_rd   <= 1'b0;
        #1;
        d = reg_rdata;
    endtask

    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        samples_checked++;
        if (got !== exp) begin
            n_errors++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic rdc(input string what, input logic [1:0] a, input logic [7:0] exp);
        rd(a, rv);
        chk(what, exp, rv);
    endtask

    task automatic test_done;
        $display("checks %0d errors %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        rst_b = 1'b0;
        reg_addr = 2'h0;
        reg_wdata = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        tx_ovf_tick = 1'b0;
        rx_ovf_tick = 1'b0;
        cycles = 0;
        n_errors = 0;
        samples_checked = 0;
        repeat (3) @(posedge clk);
        rst_b <= 1'b1;
        rdc("ctrl reset", 2'h0, 8'h00);
        rdc("buf reset", 2'h1, 8'h00);
        wr(2'h3, 8'hff);
        rdc("unmapped", 2'h3, 8'h00);
        wr(2'h2, 8'hff);
        rdc("power", 2'h2, 8'h80);
        // mode 2 transmit at both fixed rates
        for (int k = 0; k < 2; k++) begin
            wr(2'h2, k ? 8'h80 : 8'h00);
            wr(2'h0, k ? 8'h80 : 8'h88);
            fork
                i_sp_serial_peer.take(k ? 32 : 64, fr);
                wr(2'h1, k ? 8'h3c : 8'ha5);
            join
            chk("m2 data", k ? 8'h3c : 8'ha5, fr[7:0]);
            chk("m2 ninth stop", k ? 8'h02 : 8'h03, {6'h00, fr[9:8]});
            rdc("m2 tx flag", 2'h0, k ? 8'h82 : 8'h8a);
            repeat (64) @(posedge clk);
        end
        // mode 1 transmit from the timer ticks
        wr(2'h0, 8'h40);
        fork
            i_sp_serial_peer.take(32, fr);
            wr(2'h1, 8'h96);
        join
        chk("m1 data", 8'h96, fr[7:0]);
        chk("m1 stop", 8'h01, {7'h00, fr[8]});
        repeat (32) @(posedge clk);
        wr(2'h2, 8'h00);
        // receive table: accept, flag set, filter, mode 2, not allowed
        for (int i = 0; i < 6; i++) begin
            wr(2'h0, RC[i]);
            i_sp_serial_peer.send(RF[i], RC[i][7] ? 10 : 9, RC[i][7:6] == 2'h2 ? 64 : 32);
            repeat (8) @(posedge clk);
            rdc("rx ctrl", 2'h0, RE[i]);
            rdc("rx buf", 2'h1, RB[i]);
        end
        // mode 0 transmit then receive
        wr(2'h0, 8'h00);
        fork
            i_sp_serial_peer.shift8(8'h00, b8);
            wr(2'h1, 8'h5a);
        join
        repeat (16) @(posedge clk);
        chk("m0 tx", 8'h5a, b8);
        rdc("m0 tx flag", 2'h0, 8'h02);
        fork
            i_sp_serial_peer.shift8(8'hc6, b8);
            wr(2'h0, 8'h10);
        join
        repeat (16) @(posedge clk);
        rdc("m0 rx flag", 2'h0, 8'h11);
        rdc("m0 rx buf", 2'h1, 8'hc6);
        test_done();
    end
endmodule

bind sp_uart_serial_port sp_uart_serial_port_monitor #(.OVS(OVS)) i_sp_uart_serial_port_monitor (.clk(clk),
    .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .tx_ovf_tick(tx_ovf_tick), .rx_ovf_tick(rx_ovf_tick), .rxd_in(rxd_in),
    .rxd_out(rxd_out), .rxd_oe(rxd_oe), .txd_out(txd_out));
